// ===== rtl/ifd_params.svh
// Purpose: constants of the instruction format decoder
// Assumes: included by bare name
// Notes: field positions, reset values and table defaults
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH

`define IFD_OP1_LSB 12
`define IFD_DST_LSB 8
`define IFD_OP2_LSB 4
`define IFD_SRC_LSB 0
`define IFD_BYTE_SIGN 7
`define IFD_WORD_BYTES 16'h0002
`define IFD_RST_WORD 16'h0000
`define IFD_RST_DWORD 32'h0000_0000
`define IFD_BASE_IMM 4'h0
`define IFD_BASE_PCREL 4'h1
`define IFD_BASE_ABS 4'h2
`define IFD_FMT_MAP_DEF 32'h0faa_0500
`define IFD_TW_OP2_DEF 16'h0001
`define IFD_IN_OP2_DEF 16'h4000
`define IFD_OUT_OP2_DEF 16'h8000
`define IFD_BYTE_OP2_DEF 16'h0000
`define IFD_DBL_OP2_DEF 16'h0010

`endif

// ===== rtl/ifd_pkg.sv
// Purpose: types shared by the decoder and its register file
// Assumes: nothing
// Notes: bit 0 is always the least significant bit
package ifd_pkg;
  typedef logic [7:0] ifd_byte_t;
  typedef logic [15:0] ifd_word_t;
  typedef logic [31:0] ifd_dword_t;
  typedef logic [3:0] ifd_reg_t;
  typedef enum logic [2:0] {IFD_FMT_RR, IFD_FMT_RN, IFD_FMT_RI, IFD_FMT_RL, IFD_FMT_TW} ifd_fmt_e;
  typedef enum logic [1:0] {IFD_S_IDLE, IFD_S_WAIT2, IFD_S_ISSUE} ifd_state_e;
  typedef struct packed {
    ifd_state_e st;
    logic fw_ready;
    logic next_req;
    logic iss_valid;
    ifd_fmt_e fmt;
    logic [3:0] op1;
    logic [3:0] op2;
    ifd_reg_t dst;
    ifd_reg_t src;
    logic [3:0] cnt;
    ifd_word_t short_literal;
    ifd_word_t displacement_word;
    ifd_word_t ea;
    ifd_word_t addr;
    ifd_word_t opa;
    ifd_word_t opb;
    ifd_word_t bytea;
    ifd_dword_t dbla;
    ifd_dword_t dblb;
    logic imm;
    logic io_in;
    logic io_out;
    logic byte_mem;
    logic dbl;
    logic misalign;
  } ifd_state_s;
endpackage

// ===== rtl/ifd_rf_if.sv
// Purpose: read and write paths between decoder and register file
// Assumes: one clock domain
// Notes: four read ports cover register pairs of two operands
`timescale 1ns/1ps
interface ifd_rf_if;
  import ifd_pkg::*;
  ifd_reg_t ra_idx;
  ifd_reg_t rb_idx;
  ifd_word_t ra_data;
  ifd_word_t ra1_data;
  ifd_word_t rb_data;
  ifd_word_t rb1_data;
  logic wr_en;
  ifd_reg_t wr_idx;
  ifd_word_t wr_data;
  modport dec (output ra_idx, output rb_idx, output wr_en, output wr_idx, output wr_data,
    input ra_data, input ra1_data, input rb_data, input rb1_data);
  modport rf (input ra_idx, input rb_idx, input wr_en, input wr_idx, input wr_data,
    output ra_data, output ra1_data, output rb_data, output rb1_data);
endinterface

// ===== rtl/ifd_regfile.sv
// Purpose: sixteen general registers of sixteen bits
// Assumes: writes come from the execution datapath
// Notes: reads are combinational; pair partner wraps from 15 to 0
`timescale 1ns/1ps
`include "ifd_params.svh"
module ifd_regfile
  import ifd_pkg::*;
#(
  parameter int NREGS = 16
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  ifd_rf_if.rf rf
);
  ifd_word_t regs [NREGS];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREGS; i++) begin
        regs[i] <= `IFD_RST_WORD;
      end
    end else if (ce_i && rf.wr_en) begin
      regs[rf.wr_idx] <= rf.wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // more significant register first, its partner is index plus one
  assign rf.ra_data = regs[rf.ra_idx];
  assign rf.ra1_data = regs[ifd_reg_t'(rf.ra_idx + 4'h1)];
  assign rf.rb_data = regs[rf.rb_idx];
  assign rf.rb1_data = regs[ifd_reg_t'(rf.rb_idx + 4'h1)];
endmodule

// ===== rtl/ifd_decoder.sv
// Purpose: decodes one- and two-word instructions for the datapath
// Assumes: fetch and datapath on clock_i; opcode tables are parameters
// Notes: operands are read when the first word is taken; two-word opb is read again with the second word
//
// Overview of operation
// - every instruction is one or two words; length comes from opcodes
// - instructions start on even byte addresses; an odd start is still decoded and flagged on iss_misalign_o
// - bytes are eight bits, bit 0 lowest, bit 7 highest
// - words are sixteen bits, bit 0 lowest, two's complement
// - a word is addressed by its high byte at the even address
// - a double value is 32 bits addressed by its high word's high byte
// - sixteen general registers of sixteen bits, two's complement
// - register byte operations use bits 7:0, bit 7 is sign
// - double operands are register pairs named by the upper register
// - register-register: opcode, first reg, opcode, second reg nibbles
// - both registers are operands, first register receives result
// - input: first register is destination, second holds source address
// - output: second register holds target address, first is source
// - single-register: low nibble is repeat count for named register
// - immediate: opcode, register, eight-bit literal; register is destination
// - relative: low byte is displacement from the advanced counter
// - relative displacement is signed, about 128 instructions either way
// - two-word: first word has fields, second word a displacement
// - second word meaning follows the base register field
// - base 0 immediate, 1 counter relative, 2 absolute, 3-15 indexed
// - word operand addresses drop bit 0 except memory byte accesses
`timescale 1ns/1ps
`include "ifd_params.svh"
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter logic [31:0] FMT_MAP = `IFD_FMT_MAP_DEF,
  parameter logic [15:0] TW_OP2 = `IFD_TW_OP2_DEF,
  parameter logic [15:0] IN_OP2 = `IFD_IN_OP2_DEF,
  parameter logic [15:0] OUT_OP2 = `IFD_OUT_OP2_DEF,
  parameter logic [15:0] BYTE_OP2 = `IFD_BYTE_OP2_DEF,
  parameter logic [15:0] DBL_OP2 = `IFD_DBL_OP2_DEF
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic fw_valid_i,
  input wire logic [15:0] fw_word_i,
  input wire logic [15:0] fw_addr_i,
  output logic fw_ready_o,
  output logic fetch_next_o,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic iss_ready_i,
  output logic iss_valid_o,
  output ifd_fmt_e iss_fmt_o,
  output logic [3:0] iss_op1_o,
  output logic [3:0] iss_op2_o,
  output logic [3:0] iss_dst_o,
  output logic [3:0] iss_src_o,
  output logic [3:0] iss_count_o,
  output logic [15:0] iss_lit_o,
  output logic [15:0] iss_displacement_word_o,
  output logic [15:0] iss_ea_o,
  output logic [15:0] iss_opnd_a_o,
  output logic [15:0] iss_opnd_b_o,
  output logic [15:0] iss_byte_a_o,
  output logic [31:0] iss_dbl_a_o,
  output logic [31:0] iss_dbl_b_o,
  output logic iss_imm_o,
  output logic iss_io_in_o,
  output logic iss_io_out_o,
  output logic iss_byte_mem_o,
  output logic iss_dbl_o,
  output logic iss_misalign_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // two's complement sum, carry out is dropped on purpose
  function automatic ifd_word_t ifd_add(input ifd_word_t a, input ifd_word_t b);
    ifd_add = ifd_word_t'(a + b);
  endfunction

  // sign extension of a byte, bit 7 is the sign
  function automatic ifd_word_t ifd_sext8(input ifd_byte_t b);
    ifd_sext8 = {{8{b[`IFD_BYTE_SIGN]}}, b};
  endfunction

  // word data sits at the even byte, so bit 0 is dropped
  function automatic ifd_word_t ifd_even(input ifd_word_t a);
    ifd_even = {a[15:1], 1'b0};
  endfunction

  // four-bit field at a given low bit
  function automatic logic [3:0] ifd_nib(input ifd_word_t w, input int lsb);
    ifd_nib = w[lsb +: 4];
  endfunction

  function automatic ifd_fmt_e ifd_fmt_of(input logic [1:0] code, input logic two);
    ifd_fmt_of = IFD_FMT_RR;
    case (code)
      2'h1: ifd_fmt_of = IFD_FMT_RN;
      2'h2: ifd_fmt_of = IFD_FMT_RI;
      2'h3: ifd_fmt_of = IFD_FMT_RL;
      default: ifd_fmt_of = two ? IFD_FMT_TW : IFD_FMT_RR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file

  ifd_rf_if rf ();

  ifd_regfile #(
    .NREGS(16)
  ) u_regfile (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .rf(rf.rf)
  );

  ifd_state_s s;
  ifd_state_s next_s;

  // first word picks registers directly, later cycles use held fields
  assign rf.ra_idx = (s.st == IFD_S_IDLE) ? ifd_nib(fw_word_i, `IFD_DST_LSB) : s.dst;
  assign rf.rb_idx = (s.st == IFD_S_IDLE) ? ifd_nib(fw_word_i, `IFD_SRC_LSB) : s.src;
  assign rf.wr_en = wr_en_i;
  assign rf.wr_idx = wr_idx_i;
  assign rf.wr_data = wr_data_i;

  ////////////////////////////////////////////////////////////////////////
  // first word field split

  logic [3:0] f_op1;
  logic [3:0] f_op2;
  logic [3:0] f_dst;
  logic [3:0] f_src;
  logic [1:0] f_code;
  logic f_two;
  ifd_word_t f_pc;
  ifd_word_t f_low;

  always_comb begin
    f_op1 = ifd_nib(fw_word_i, `IFD_OP1_LSB);
    f_dst = ifd_nib(fw_word_i, `IFD_DST_LSB);
    f_op2 = ifd_nib(fw_word_i, `IFD_OP2_LSB);
    f_src = ifd_nib(fw_word_i, `IFD_SRC_LSB);
    f_code = FMT_MAP[{f_op1, 1'b0} +: 2];
    f_two = (f_code == 2'h0) && TW_OP2[f_op2];
    // counter already points at the following word
    f_pc = ifd_add(fw_addr_i, `IFD_WORD_BYTES);
    f_low = ifd_sext8(fw_word_i[7:0]);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing and decode

  always_comb begin
    next_s = s;
    next_s.next_req = 1'b0;
    case (s.st)
      IFD_S_IDLE: begin
        if (fw_valid_i && s.fw_ready) begin
          next_s.fmt = ifd_fmt_of(f_code, f_two);
          next_s.op1 = f_op1;
          next_s.op2 = f_op2;
          next_s.dst = f_dst;
          next_s.src = f_src;
          next_s.addr = fw_addr_i;
          next_s.misalign = fw_addr_i[0];
          next_s.cnt = 4'h0;
          next_s.short_literal = `IFD_RST_WORD;
          next_s.displacement_word = `IFD_RST_WORD;
          next_s.ea = `IFD_RST_WORD;
          next_s.imm = 1'b0;
          next_s.io_in = 1'b0;
          next_s.io_out = 1'b0;
          next_s.byte_mem = 1'b0;
          next_s.dbl = 1'b0;
          // register operands, result goes to the first register
          next_s.opa = rf.ra_data;
          next_s.opb = rf.rb_data;
          next_s.bytea = ifd_sext8(rf.ra_data[7:0]);
          next_s.dbla = {rf.ra_data, rf.ra1_data};
          next_s.dblb = {rf.rb_data, rf.rb1_data};
          case (f_code)
            2'h1: begin
              next_s.cnt = f_src;
            end
            2'h2: begin
              next_s.short_literal = f_low;
            end
            2'h3: begin
              // displacement counts words, so shift to bytes
              next_s.displacement_word = f_low;
              next_s.ea = ifd_add(f_pc, {f_low[14:0], 1'b0});
            end
            default: begin
              next_s.dbl = DBL_OP2[f_op2];
              next_s.byte_mem = f_two && BYTE_OP2[f_op2];
              if (!f_two && IN_OP2[f_op2]) begin
                next_s.io_in = 1'b1;
                next_s.ea = ifd_even(rf.rb_data);
              end else if (!f_two && OUT_OP2[f_op2]) begin
                next_s.io_out = 1'b1;
                next_s.ea = ifd_even(rf.rb_data);
              end
            end
          endcase
          if (f_two) begin
            next_s.st = IFD_S_WAIT2;
            next_s.next_req = 1'b1;
            next_s.fw_ready = 1'b1;
          end else begin
            next_s.st = IFD_S_ISSUE;
            next_s.fw_ready = 1'b0;
            next_s.iss_valid = 1'b1;
          end
        end else begin
          next_s.fw_ready = 1'b1;
        end
      end
      IFD_S_WAIT2: begin
        // fields stay held until the displacement word turns up
        if (fw_valid_i) begin
          next_s.displacement_word = fw_word_i;
          next_s.opb = rf.rb_data;
          case (s.src)
            `IFD_BASE_IMM: begin
              next_s.imm = 1'b1;
              next_s.opb = fw_word_i;
              next_s.ea = ifd_add(s.addr, `IFD_WORD_BYTES);
            end
            `IFD_BASE_PCREL: begin
              next_s.ea = ifd_add(ifd_add(s.addr, `IFD_WORD_BYTES), fw_word_i);
            end
            `IFD_BASE_ABS: begin
              next_s.ea = fw_word_i;
            end
            default: begin
              next_s.ea = ifd_add(fw_word_i, rf.rb_data);
            end
          endcase
          // word data lives at the even byte; byte moves keep bit 0
          if (!s.byte_mem && s.src != `IFD_BASE_IMM) begin
            next_s.ea = ifd_even(next_s.ea);
          end
          next_s.st = IFD_S_ISSUE;
          next_s.fw_ready = 1'b0;
          next_s.iss_valid = 1'b1;
        end
      end
      IFD_S_ISSUE: begin
        // operands captured at decode: a write landing before issue is
        // not seen, the datapath must forward it
        if (iss_ready_i) begin
          next_s.iss_valid = 1'b0;
          next_s.st = IFD_S_IDLE;
          next_s.fw_ready = 1'b1;
        end
      end
      default: begin
        next_s.st = IFD_S_IDLE;
        next_s.iss_valid = 1'b0;
        next_s.fw_ready = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, frozen while ce_i is low

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign fw_ready_o = s.fw_ready;
  assign fetch_next_o = s.next_req;
  assign iss_valid_o = s.iss_valid;
  assign iss_fmt_o = s.fmt;
  assign iss_op1_o = s.op1;
  assign iss_op2_o = s.op2;
  assign iss_dst_o = s.dst;
  assign iss_src_o = s.src;
  assign iss_count_o = s.cnt;
  assign iss_lit_o = s.short_literal;
  assign iss_displacement_word_o = s.displacement_word;
  assign iss_ea_o = s.ea;
  assign iss_opnd_a_o = s.opa;
  assign iss_opnd_b_o = s.opb;
  assign iss_byte_a_o = s.bytea;
  assign iss_dbl_a_o = s.dbla;
  assign iss_dbl_b_o = s.dblb;
  assign iss_imm_o = s.imm;
  assign iss_io_in_o = s.io_in;
  assign iss_io_out_o = s.io_out;
  assign iss_byte_mem_o = s.byte_mem;
  assign iss_dbl_o = s.dbl;
  assign iss_misalign_o = s.misalign;
endmodule

// ===== dv/ifd_decoder_sva.sv
// Purpose: port-level checks of the instruction format decoder
// Assumes: one clock domain, ce_i dropped by the bench only while idle
// Notes: sees only the top module's ports
`timescale 1ns/1ps
module ifd_decoder_sva
  import ifd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic fw_ready_o,
  input wire logic fetch_next_o,
  input wire logic iss_ready_i,
  input wire logic iss_valid_o,
  input wire ifd_fmt_e iss_fmt_o,
  input wire logic [3:0] iss_dst_o,
  input wire logic [3:0] iss_count_o,
  input wire logic [15:0] iss_lit_o,
  input wire logic [15:0] iss_displacement_word_o,
  input wire logic [15:0] iss_ea_o,
  input wire logic [15:0] iss_opnd_a_o,
  input wire logic [15:0] iss_byte_a_o,
  input wire logic [31:0] iss_dbl_a_o,
  input wire logic iss_imm_o,
  input wire logic iss_byte_mem_o,
  input wire logic iss_misalign_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready_off;
    iss_valid_o |-> !fw_ready_o;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("fetch ready while issue pending");
  property p_hold;
    iss_valid_o && !iss_ready_i |=> iss_valid_o && $stable(iss_ea_o) && $stable(iss_dst_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("issue fields moved while stalled");
  property p_accept;
    iss_valid_o && iss_ready_i |=> !iss_valid_o && fw_ready_o;
  endproperty
  a_accept: assert property (p_accept)
    else $error("issue not retired after acceptance");
  property p_next;
    fetch_next_o |-> fw_ready_o && !iss_valid_o ##1 !fetch_next_o;
  endproperty
  a_next: assert property (p_next)
    else $error("second word request malformed");
  property p_count;
    iss_valid_o && iss_fmt_o != IFD_FMT_RN |-> iss_count_o == 4'h0;
  endproperty
  a_count: assert property (p_count)
    else $error("repeat count outside single register format");
  property p_lit;
    iss_valid_o |-> iss_lit_o == (iss_fmt_o == IFD_FMT_RI ?
      {{8{iss_lit_o[7]}}, iss_lit_o[7:0]} : 16'h0000);
  endproperty
  a_lit: assert property (p_lit)
    else $error("literal not sign extended");
  property p_rel;
    iss_valid_o && iss_fmt_o == IFD_FMT_RL && !iss_misalign_o |->
      !iss_ea_o[0] && iss_displacement_word_o[15:8] == {8{iss_displacement_word_o[7]}};
  endproperty
  a_rel: assert property (p_rel)
    else $error("relative target malformed");
  property p_even;
    iss_valid_o && iss_fmt_o == IFD_FMT_TW && !iss_imm_o && !iss_byte_mem_o |-> !iss_ea_o[0];
  endproperty
  a_even: assert property (p_even)
    else $error("word operand address odd");
  property p_dbl;
    iss_valid_o |-> iss_dbl_a_o[31:16] == iss_opnd_a_o && iss_byte_a_o[7:0] == iss_opnd_a_o[7:0];
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("pair or byte operand not from named register");
  ////////////////////////////////////////////////////////////////////////////////
  c_tw: cover property (iss_valid_o && iss_ready_i && iss_fmt_o == IFD_FMT_TW);
  c_rl: cover property (iss_valid_o && iss_ready_i && iss_fmt_o == IFD_FMT_RL);
  c_stall: cover property (iss_valid_o && !iss_ready_i ##1 iss_ready_i);
endmodule

// ===== dv/ifd_dp_model.sv
// Purpose: execution datapath side of the issue handshake
// Assumes: ready sampled at the rising edge
// Notes: random stalls prove that issued fields hold
`timescale 1ns/1ps
module ifd_dp_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic iss_valid_o,
  output logic iss_ready_i
);
  initial iss_ready_i = 1'b0;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) iss_ready_i <= 1'b0;
    // ready drops after each acceptance, so every issue may see a stall
    else iss_ready_i <= (iss_valid_o && iss_ready_i) ? 1'b0 : ($urandom_range(3) != 0);
  end
endmodule

// ===== dv/test_ifd_decoder.sv
// Purpose: self-checking bench of the instruction format decoder
// Assumes: default opcode tables, ce_i high except in the frozen-enable check
// Notes: expectations come from a register snapshot taken with the word
`timescale 1ns/1ps
`include "ifd_params.svh"
module test_ifd_decoder;
  import ifd_pkg::*;
  localparam logic [31:0] FM = `IFD_FMT_MAP_DEF;
  localparam logic [15:0] TW = `IFD_TW_OP2_DEF;
  localparam logic [15:0] IN = `IFD_IN_OP2_DEF;
  localparam logic [15:0] OUT = `IFD_OUT_OP2_DEF;
  localparam logic [15:0] DB = `IFD_DBL_OP2_DEF;
  localparam logic [15:0] BY = `IFD_BYTE_OP2_DEF;
  logic clock_i = 0, rst_i = 1, ce_i = 1, fw_valid_i = 0, wr_en_i = 0, iss_ready_i;
  logic [15:0] fw_word_i = 0, fw_addr_i = 0, wr_data_i = 0;
  logic [3:0] wr_idx_i = 0;
  logic fw_ready_o, fetch_next_o, iss_valid_o, iss_imm_o, iss_io_in_o, iss_io_out_o;
  logic iss_byte_mem_o, iss_dbl_o, iss_misalign_o, take_iss;
  ifd_fmt_e iss_fmt_o;
  logic [3:0] iss_op1_o, iss_op2_o, iss_dst_o, iss_src_o, iss_count_o;
  logic [15:0] iss_lit_o, iss_displacement_word_o, iss_ea_o, iss_opnd_a_o, iss_opnd_b_o, iss_byte_a_o;
  logic [31:0] iss_dbl_a_o, iss_dbl_b_o;
  logic [15:0] regs [16], snap [16];
  int num_errors = 0, checked = 0;
  assign take_iss = iss_valid_o && iss_ready_i;
  ifd_decoder i_ifd_decoder (.*);
  ifd_dp_model i_ifd_dp_model (.*);
  always #2 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait, returns between edges with the signal high
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge clock_i);
    while (s !== 1'b1) begin
      n++;
      if (n > 200) begin
        num_errors++;
        close_out();
      end
      @(negedge clock_i);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    @(posedge clock_i);
    wr_en_i <= 1'b1;
    wr_idx_i <= i;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
    regs[i] = d;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [15:0] w, input logic [15:0] a, input logic [15:0] w2);
    logic [3:0] o2, d, s;
    logic [1:0] c;
    logic tw, io;
    logic [15:0] sx, ea, nd;
    o2 = w[7:4];
    d = w[11:8];
    s = w[3:0];
    c = FM[2 * w[15:12] +: 2];
    tw = c == 2'h0 && TW[o2];
    io = c == 2'h0 && !tw && (IN[o2] || OUT[o2]);
    sx = {{8{w[7]}}, w[7:0]};
    nd = 16'($urandom);
    @(posedge clock_i);
    fw_valid_i <= 1'b1;
    fw_word_i <= w;
    fw_addr_i <= a;
    wait_hi(fw_ready_o);
    @(posedge clock_i);
    snap = regs;
    fw_valid_i <= 1'b0;
    fw_word_i <= ~w;
    // a write after the take must not reach the issued operands
    if (!tw) begin
      wr_en_i <= 1'b1;
      wr_idx_i <= d;
      wr_data_i <= nd;
    end else begin
      wait_hi(fetch_next_o);
      @(posedge clock_i);
      fw_valid_i <= 1'b1;
      fw_word_i <= w2;
      fw_addr_i <= a + 16'h0002;
      wait_hi(fw_ready_o);
      @(posedge clock_i);
      fw_valid_i <= 1'b0;
      fw_word_i <= ~w2;
    end
    ea = c == 2'h3 ? a + 16'h0002 + {sx[14:0], 1'b0} : io ? snap[s] & 16'hfffe : 16'h0000;
    if (tw) ea = s == 0 ? a + 16'h0002 : s == 1 ? a + 16'h0002 + w2 : s == 2 ? w2 : w2 + snap[s];
    if (tw && s != 0 && !BY[o2]) ea[0] = 1'b0;
    wait_hi(take_iss);
    cmp(iss_fmt_o, tw ? 4 : c);
    cmp({iss_op1_o, iss_dst_o, iss_op2_o, iss_src_o}, w);
    cmp(iss_count_o, c == 2'h1 ? s : 4'h0);
    cmp(iss_lit_o, c == 2'h2 ? sx : 16'h0000);
    cmp(iss_displacement_word_o, c == 2'h3 ? sx : tw ? w2 : 16'h0000);
    cmp(iss_ea_o, ea);
    cmp({iss_imm_o, iss_io_in_o, iss_io_out_o, iss_dbl_o, iss_misalign_o, iss_byte_mem_o},
      {tw && s == 0, io && IN[o2], io && OUT[o2], c == 2'h0 && DB[o2], a[0],
      tw && BY[o2]});
    cmp({iss_opnd_a_o, iss_opnd_b_o}, {snap[d], tw && s == 0 ? w2 : snap[s]});
    cmp(iss_byte_a_o, {{8{snap[d][7]}}, snap[d][7:0]});
    cmp({iss_dbl_a_o, iss_dbl_b_o}, {snap[d], snap[d + 4'h1], snap[s], snap[s + 4'h1]});
    @(posedge clock_i);
    wr_en_i <= 1'b0;
    if (!tw) regs[d] = nd;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] w;
    void'($urandom(85));
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) wr(4'(i), 16'($urandom));
    wr(4'h4, 16'h01ac);
    for (int b = 0; b < 5; b++) send(16'h0500 | 16'(b), 16'h10ac, 16'h01b0);
    send(16'hc080, 16'h0100, 16'h0000);
    send(16'hd07f, 16'h0100, 16'h0000);
    send(16'h1234, 16'h0101, 16'h0000);
    repeat (300) begin
      w = 16'($urandom);
      send(w, 16'($urandom) & 16'hfffe, 16'($urandom));
      if (w[0]) wr(w[11:8], 16'($urandom));
    end
    // mid-run reset: handshake outputs drop and the registers clear
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    cmp({iss_valid_o, fetch_next_o, fw_ready_o, iss_ea_o, iss_dst_o}, 64'h0);
    @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (regs[i]) regs[i] = `IFD_RST_WORD;
    // frozen enable: neither the write nor the offered word may land
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr_en_i <= 1'b1;
    wr_idx_i <= 4'h3;
    wr_data_i <= 16'h5a5a;
    fw_valid_i <= 1'b1;
    fw_word_i <= 16'h1334;
    repeat (3) @(posedge clock_i);
    ce_i <= 1'b1;
    wr_en_i <= 1'b0;
    fw_valid_i <= 1'b0;
    @(negedge clock_i);
    cmp({iss_valid_o, fetch_next_o, fw_ready_o}, 3'b001);
    send(16'h1334, 16'h0200, 16'h0000);
    close_out();
  end
endmodule
bind ifd_decoder ifd_decoder_sva i_sva (.*);
